// ===== rtl/iem_top.sv
// Top: warning C filter, event flags and interrupt mask logic
`timescale 1ns/1ps
module iem_top (
  input  wire logic                 clock_in,        // System clock, 10 MHz
  input  wire logic                 rst_in,          // Async reset, high
  input  iem_pkg::iem_reg_req_s     reg_req_in,      // Register access request
  output logic [15:0]               rd_data_out,     // Register read data
  input  wire logic [7:0]           ch1_adc_in,      // Channel 1 ADC value
  input  wire logic [7:0]           ch2_adc_in,      // Channel 2 ADC value
  input  wire logic [15:0]          warn_c_thr_in,   // Warning C thresholds lo/hi
  input  iem_pkg::iem_chan_s        ch1_in,          // Channel 1 A, B, output levels
  input  iem_pkg::iem_chan_s        ch2_in,          // Channel 2 A, B, output levels
  input  iem_pkg::iem_fault_s       fault_in,        // Fault and busy levels
  input  wire logic                 sample_ready_in, // ADC sample ready pulse
  output logic                      ch1_warn_c_out,  // Channel 1 filtered warning C
  output logic                      ch2_warn_c_out,  // Channel 2 filtered warning C
  output logic                      irq_out          // Interrupt output, high
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  iem_pkg::iem_top_s           st_ff;
  iem_pkg::iem_top_s           nxt_st;
  logic                        tick;
  logic                        cfg_en;
  logic                        cfg_updn;
  logic [iem_pkg::LEN_W-1:0]   cfg_len;
  logic [7:0]                  thr_lo;
  logic [7:0]                  thr_hi;
  logic                        wc1;
  logic                        wc2;
  logic [iem_pkg::EV_W-2:0]    cur_lvl;
  logic [iem_pkg::EV_W-1:0]    ev;
  logic [iem_pkg::EV_W-1:0]    clr;
  logic                        wr_status;

  // ---------------------------------------------------------------
  // Configuration fields
  // ---------------------------------------------------------------
  assign cfg_en   = st_ff.cfg[iem_pkg::CFG_EN_BIT];
  assign cfg_updn = st_ff.cfg[iem_pkg::CFG_UPDN_BIT];
  assign cfg_len  = st_ff.cfg[iem_pkg::LEN_W-1:0];
  assign thr_lo   = warn_c_thr_in[iem_pkg::THR_LO_MSB:iem_pkg::THR_LO_LSB];
  assign thr_hi   = warn_c_thr_in[iem_pkg::THR_HI_MSB:0];

  // Filter time step: one pulse every 20 us
  assign tick = (st_ff.tick_cnt == iem_pkg::TICK_W'(iem_pkg::TICK_CYCLES - 1));

  // ---------------------------------------------------------------
  // Warning C filters, one per channel
  // ---------------------------------------------------------------
  iem_debounce #(
    .LEN_W     (iem_pkg::LEN_W)
  ) u_filt_ch1 (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .tick_in   (tick),
    .raw_in    (st_ff.cmp1),
    .enable_in (cfg_en),
    .updown_in (cfg_updn),
    .length_in (cfg_len),
    .filt_out  (wc1)
  );

  iem_debounce #(
    .LEN_W     (iem_pkg::LEN_W)
  ) u_filt_ch2 (
    .clock_in  (clock_in),
    .rst_in    (rst_in),
    .tick_in   (tick),
    .raw_in    (st_ff.cmp2),
    .enable_in (cfg_en),
    .updown_in (cfg_updn),
    .length_in (cfg_len),
    .filt_out  (wc2)
  );

  assign ch1_warn_c_out = wc1;
  assign ch2_warn_c_out = wc2;

  // ---------------------------------------------------------------
  // Event sources, ordered as the status and mask bits
  // ---------------------------------------------------------------
  assign cur_lvl = {fault_in.busy,
                    fault_in.cool2, fault_in.cool1,
                    fault_in.thermal,
                    fault_in.iso_err,
                    fault_in.mismatch,
                    wc2, ch2_in.warn_b, ch2_in.warn_a,
                    ch2_in.dout,
                    wc1, ch1_in.warn_b, ch1_in.warn_a,
                    ch1_in.dout};

  // Only low-to-high transitions count; reset-done fires once
  assign ev = {~st_ff.rst_seen, cur_lvl & ~st_ff.prev_lvl};

  // Write one clears, write zero leaves the flag; no lock gating
  assign wr_status = reg_req_in.wr && (reg_req_in.addr == iem_pkg::ADDR_STATUS);
  assign clr       = wr_status ? reg_req_in.wdata[iem_pkg::EV_W-1:0] : '0;

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Tick prescaler
    if (tick) begin
      nxt_st.tick_cnt = '0;
    end else begin
      nxt_st.tick_cnt = iem_pkg::TICK_W'(st_ff.tick_cnt + 1'b1);
    end

    // Hysteresis comparators; set has priority if thresholds cross
    if (ch1_adc_in > thr_hi) begin
      nxt_st.cmp1 = 1'b1;
    end else if (ch1_adc_in <= thr_lo) begin
      nxt_st.cmp1 = 1'b0;
    end
    if (ch2_adc_in > thr_hi) begin
      nxt_st.cmp2 = 1'b1;
    end else if (ch2_adc_in <= thr_lo) begin
      nxt_st.cmp2 = 1'b0;
    end

    nxt_st.prev_lvl = cur_lvl;
    nxt_st.rst_seen = 1'b1;

    // Sticky flags: a new event wins over a same-cycle clear
    nxt_st.status = (st_ff.status & ~clr) | ev;

    // Register writes; reserved config bit stays zero
    if (reg_req_in.wr && (reg_req_in.addr == iem_pkg::ADDR_FILT_C)) begin
      nxt_st.cfg = reg_req_in.wdata;
      nxt_st.cfg[iem_pkg::CFG_RSVD_BIT] = 1'b0;
    end
    if (reg_req_in.wr && (reg_req_in.addr == iem_pkg::ADDR_MASK)) begin
      nxt_st.mask = reg_req_in.wdata;
    end

    // Interrupt: sample-ready pulses when MASK_DRDY_BIT is set, else any enabled latched flag
    if (nxt_st.mask[iem_pkg::MASK_DRDY_BIT]) begin
      nxt_st.irq = sample_ready_in;
    end else begin
      nxt_st.irq = |(nxt_st.status & nxt_st.mask[iem_pkg::EV_W-1:0]);
    end

    // Read data, registered; unmapped addresses read zero
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        iem_pkg::ADDR_FILT_C: nxt_st.rd_data = st_ff.cfg;
        iem_pkg::ADDR_MASK:   nxt_st.rd_data = st_ff.mask;
        iem_pkg::ADDR_STATUS: nxt_st.rd_data = {1'b0, st_ff.status};
        default:              nxt_st.rd_data = '0;
      endcase
    end
  end

  // Config and mask take their documented values under reset
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= iem_pkg::TOP_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign rd_data_out = st_ff.rd_data;
  assign irq_out     = st_ff.irq;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence seq_status_wr;
    wr_status && (ev == '0);
  endsequence

  sequence seq_event;
    ev != '0;
  endsequence

  AST_SET_WINS: assert property (
    seq_event |=> ((st_ff.status & $past(ev)) == $past(ev)))
    else $error("event flag lost");

  AST_W1C: assert property (
    seq_status_wr |=> ((st_ff.status & $past(clr)) == '0)
      && ((st_ff.status & ~$past(clr)) == ($past(st_ff.status) & ~$past(clr))))
    else $error("write one did not clear or write zero changed a flag");

  AST_IRQ_LEVEL: assert property (
    !st_ff.mask[iem_pkg::MASK_DRDY_BIT]
    |-> irq_out == |(st_ff.status & st_ff.mask[iem_pkg::EV_W-1:0]))
    else $error("interrupt does not match enabled flags");

  AST_DRDY: assert property (
    nxt_st.mask[iem_pkg::MASK_DRDY_BIT] && sample_ready_in ##1
      st_ff.mask[iem_pkg::MASK_DRDY_BIT]
    |-> irq_out ##1 (irq_out == $past(sample_ready_in)))
    else $error("sample-ready pulse not forwarded");

  AST_RESET_COMPLETE_EVENT: assert property (
    $rose(st_ff.rst_seen) |-> st_ff.status[iem_pkg::EV_RESET_COMPLETE_EVENT]
      && (st_ff.mask == iem_pkg::MASK_RESET))
    else $error("reset-done flag or mask reset value wrong");

  AST_CFG_RESET: assert property (
    $rose(st_ff.rst_seen) |-> st_ff.cfg == iem_pkg::FILT_C_RESET)
    else $error("filter config reset value wrong");

  AST_TICK: assert property (
    tick |=> !tick [*8])
    else $error("filter tick period too short");

  AST_CMP: assert property (
    (ch1_adc_in > thr_hi) |=> st_ff.cmp1)
    else $error("comparator not set above high threshold");

  // Inside the hysteresis band the comparator must not chatter
  AST_CMP_HOLD: assert property (
    (ch1_adc_in > thr_lo) && (ch1_adc_in <= thr_hi) |=> $stable(st_ff.cmp1))
    else $error("comparator changed inside the hysteresis band");

  AST_CMP_LO: assert property (
    (ch2_adc_in <= thr_lo) && (ch2_adc_in <= thr_hi) |=> !st_ff.cmp2)
    else $error("comparator not cleared at low threshold");

  // Each rising source but busy latches its own flag; catches a swapped bit order
  AST_EV_COOL2: assert property (
    $rose(fault_in.cool2) |=> st_ff.status[iem_pkg::EV_COOL2])
    else $error("channel 2 cool-down flag not latched");

  AST_EV_COOL1: assert property (
    $rose(fault_in.cool1) |=> st_ff.status[iem_pkg::EV_COOL1])
    else $error("channel 1 cool-down flag not latched");

  AST_EV_THERMAL: assert property (
    $rose(fault_in.thermal) |=> st_ff.status[iem_pkg::EV_THERMAL])
    else $error("thermal load-off flag not latched");

  AST_EV_LINK: assert property (
    $rose(fault_in.iso_err) |=> st_ff.status[iem_pkg::EV_LINK])
    else $error("isolation link error flag not latched");

  AST_EV_MISMATCH: assert property (
    $rose(fault_in.mismatch) |=> st_ff.status[iem_pkg::EV_MISMATCH])
    else $error("register mismatch flag not latched");

  AST_EV_CH2_WARN_C: assert property (
    $rose(wc2) |=> st_ff.status[iem_pkg::EV_CH2_WARN_C])
    else $error("channel 2 warning C flag not latched");

  AST_EV_CH2_WARN_B: assert property (
    $rose(ch2_in.warn_b) |=> st_ff.status[iem_pkg::EV_CH2_WARN_B])
    else $error("channel 2 warning B flag not latched");

  AST_EV_CH2_WARN_A: assert property (
    $rose(ch2_in.warn_a) |=> st_ff.status[iem_pkg::EV_CH2_WARN_A])
    else $error("channel 2 warning A flag not latched");

  AST_EV_CH2_OUT: assert property (
    $rose(ch2_in.dout) |=> st_ff.status[iem_pkg::EV_CH2_OUT])
    else $error("channel 2 output flag not latched");

  AST_EV_CH1_WARN_C: assert property (
    $rose(wc1) |=> st_ff.status[iem_pkg::EV_CH1_WARN_C])
    else $error("channel 1 warning C flag not latched");

  AST_EV_CH1_WARN_B: assert property (
    $rose(ch1_in.warn_b) |=> st_ff.status[iem_pkg::EV_CH1_WARN_B])
    else $error("channel 1 warning B flag not latched");

  AST_EV_CH1_WARN_A: assert property (
    $rose(ch1_in.warn_a) |=> st_ff.status[iem_pkg::EV_CH1_WARN_A])
    else $error("channel 1 warning A flag not latched");

  AST_EV_CH1_OUT: assert property (
    $rose(ch1_in.dout) |=> st_ff.status[iem_pkg::EV_CH1_OUT])
    else $error("channel 1 output flag not latched");

endmodule : iem_top

// ===== rtl/iem_pkg.sv
// Package: constants, carriers and state types of the interrupt enable block
package iem_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned TICK_US     = 20;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_W      = 8;

  // ---------------------------------------------------------------
  // Register map and reset values
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W       = 10;
  localparam logic [9:0]  ADDR_FILT_C  = 10'h00A;
  localparam logic [9:0]  ADDR_MASK    = 10'h00B;
  localparam logic [9:0]  ADDR_STATUS  = 10'h00C;
  localparam logic [15:0] FILT_C_RESET = 16'h80FA;
  localparam logic [15:0] MASK_RESET   = 16'h4000;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned CFG_EN_BIT    = 15;
  localparam int unsigned CFG_UPDN_BIT  = 14;
  localparam int unsigned CFG_RSVD_BIT  = 13;
  localparam int unsigned LEN_W         = 13;
  localparam int unsigned MASK_DRDY_BIT = 15;
  localparam int unsigned EV_W          = 15;
  localparam int unsigned EV_RESET_COMPLETE_EVENT    = 14;
  localparam int unsigned EV_COOL2      = 12;
  localparam int unsigned EV_COOL1      = 11;
  localparam int unsigned EV_THERMAL    = 10;
  localparam int unsigned EV_LINK       = 9;
  localparam int unsigned EV_MISMATCH   = 8;
  localparam int unsigned EV_CH2_WARN_C = 7;
  localparam int unsigned EV_CH2_WARN_B = 6;
  localparam int unsigned EV_CH2_WARN_A = 5;
  localparam int unsigned EV_CH2_OUT    = 4;
  localparam int unsigned EV_CH1_WARN_C = 3;
  localparam int unsigned EV_CH1_WARN_B = 2;
  localparam int unsigned EV_CH1_WARN_A = 1;
  localparam int unsigned EV_CH1_OUT    = 0;
  localparam int unsigned THR_LO_MSB    = 15;
  localparam int unsigned THR_LO_LSB    = 8;
  localparam int unsigned THR_HI_MSB    = 7;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [15:0] wdata;
  } iem_reg_req_s;

  typedef struct packed {
    logic warn_b;
    logic warn_a;
    logic dout;
  } iem_chan_s;

  typedef struct packed {
    logic busy;
    logic cool2;
    logic cool1;
    logic thermal;
    logic iso_err;
    logic mismatch;
  } iem_fault_s;

  // All state of the top module
  typedef struct packed {
    logic [TICK_W-1:0] tick_cnt;
    logic [15:0]       cfg;
    logic [15:0]       mask;
    logic [EV_W-1:0]   status;
    logic [EV_W-2:0]   prev_lvl;
    logic              cmp1;
    logic              cmp2;
    logic              rst_seen;
    logic              irq;
    logic [15:0]       rd_data;
  } iem_top_s;

  localparam iem_top_s TOP_RESET = '{
    tick_cnt: '0, cfg: FILT_C_RESET, mask: MASK_RESET, status: '0,
    prev_lvl: '0, cmp1: 1'b0, cmp2: 1'b0, rst_seen: 1'b0, irq: 1'b0,
    rd_data: '0};

endpackage : iem_pkg

// ===== rtl/iem_debounce.sv
// Debounce filter for one filtered warning comparator output
`timescale 1ns/1ps
module iem_debounce #(
  parameter int unsigned LEN_W = 13
) (
  input  wire logic             clock_in,   // System clock
  input  wire logic             rst_in,     // Async reset, high
  input  wire logic             tick_in,    // Filter time step pulse
  input  wire logic             raw_in,     // Comparator output
  input  wire logic             enable_in,  // Comparator enable
  input  wire logic             updown_in,  // Up/down counting mode
  input  wire logic [LEN_W-1:0] length_in,  // Filter length in ticks
  output logic                  filt_out    // Filtered output
);

  typedef struct packed {
    logic [LEN_W-1:0] cnt;
    logic             held;
  } iem_dbn_s;

  iem_dbn_s st_ff;
  iem_dbn_s nxt_st;
  logic     bypass;

  assign bypass = (length_in == '0);

  // ---------------------------------------------------------------
  // Counter and held value
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;
    if (!enable_in) begin
      nxt_st.cnt  = '0;
      nxt_st.held = 1'b0;
    end else if (bypass) begin
      nxt_st.cnt  = '0;
      nxt_st.held = raw_in;
    end else if (tick_in) begin
      if (raw_in != st_ff.held) begin
        // Change must persist length ticks before it is taken
        if (LEN_W'(st_ff.cnt + 1'b1) >= length_in) begin
          nxt_st.held = raw_in;
          nxt_st.cnt  = '0;
        end else begin
          nxt_st.cnt = LEN_W'(st_ff.cnt + 1'b1);
        end
      end else if (updown_in) begin
        if (st_ff.cnt != '0) begin
          nxt_st.cnt = LEN_W'(st_ff.cnt - 1'b1);
        end
      end else begin
        nxt_st.cnt = '0;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Bypass path is combinational so it adds no latency
  assign filt_out = enable_in & (bypass ? raw_in : st_ff.held);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  AST_DBN_BYPASS: assert property (
    enable_in && bypass |-> filt_out == raw_in)
    else $error("bypassed filter does not follow input");

  AST_DBN_OFF: assert property (
    !enable_in |-> !filt_out)
    else $error("disabled comparator output not low");

  AST_DBN_LENGTH: assert property (
    $past(enable_in) && enable_in && ($past(length_in) != '0)
      && $changed(st_ff.held)
    |-> $past(tick_in) && ($past(st_ff.cnt) == LEN_W'($past(length_in) - 1'b1)))
    else $error("filtered output changed before length elapsed");

  AST_DBN_CLEAR: assert property (
    enable_in && !bypass && tick_in && !updown_in && (raw_in == st_ff.held)
    |=> st_ff.cnt == '0)
    else $error("up/clear counter not cleared on revert");

endmodule : iem_debounce

// ===== test/iem_host_model.sv
// Host controller model that drives the register request port
`timescale 1ns/1ps
module iem_host_model (
  input  wire logic             clock_in,   // System clock
  input  wire logic [15:0]      rd_data_in, // Register read data
  output iem_pkg::iem_reg_req_s req_out     // Register access request
);
  // ---------------------------------------------------------------
  // Register access tasks
  // ---------------------------------------------------------------
  // Idle request from time zero
  initial req_out = '0;

  // One strobe cycle, released only at the edge that takes it
  task automatic write_reg(input logic [9:0] addr, input logic [15:0] data);
    @(posedge clock_in);
    req_out <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
    @(posedge clock_in);
    req_out <= '0;
  endtask : write_reg

  // Data holds until the next read, so a late sample is safe
  task automatic read_reg(input logic [9:0] addr, output logic [15:0] data);
    @(posedge clock_in);
    req_out <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 16'h0000};
    @(posedge clock_in);
    req_out <= '0;
    @(posedge clock_in);
    #1 data = rd_data_in;
  endtask : read_reg

  // Sample mode ignores the flag enables; this sets only the ready enable
  task automatic set_sample_mode();
    write_reg(iem_pkg::ADDR_MASK, 16'h8000);
  endtask : set_sample_mode

  // A link error that returns means lost settings: write them again
  task automatic restore_cfg(input logic [15:0] cfg);
    write_reg(iem_pkg::ADDR_FILT_C, cfg);
  endtask : restore_cfg
endmodule : iem_host_model

// ===== test/tb_top.sv
// Self-checking bench for the interrupt enable block
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin checked++; if ((got) !== (exp)) begin miscompares++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module tb_top;
  logic                  clock_in;
  logic                  rst_in = 1'b1;
  logic                  sample_ready_in = 1'b0;
  logic [7:0]            adc = 8'h00;
  logic [13:0]           lv = '0;
  logic [15:0]           rd_data_out;
  logic [15:0]           rd;
  logic                  ch1_warn_c_out;
  logic                  ch2_warn_c_out;
  logic                  irq_out;
  iem_pkg::iem_reg_req_s reg_req;
  int                    miscompares = 0;
  int                    checked = 0;
  int                    cycles = 0;

  // ---------------------------------------------------------------
  // Design, host model, clock and watchdog
  // ---------------------------------------------------------------
  // Thresholds fixed: low 0x20, high 0x40
  iem_top dut (
    .clock_in(clock_in), .rst_in(rst_in), .reg_req_in(reg_req), .rd_data_out(rd_data_out),
    .ch1_adc_in(adc), .ch2_adc_in(adc), .warn_c_thr_in(16'h2040),
    .ch1_in(lv[2:0]), .ch2_in(lv[6:4]), .fault_in(lv[13:8]),
    .sample_ready_in(sample_ready_in), .ch1_warn_c_out(ch1_warn_c_out),
    .ch2_warn_c_out(ch2_warn_c_out), .irq_out(irq_out));

  iem_host_model host (.clock_in(clock_in), .rd_data_in(rd_data_out), .req_out(reg_req));

  // 100 ns period
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // Run needs about 4600 cycles; ceiling leaves wide margin
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : give_verdict

  task automatic wait_edges(input int n);
    repeat (n) @(posedge clock_in);
    #1;
  endtask : wait_edges

  // ---------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------
  initial begin
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    wait_edges(2);
    `CHECK_EQ(irq_out, 1'b1)
    host.read_reg(iem_pkg::ADDR_FILT_C, rd);
    `CHECK_EQ(rd, 16'h80FA)
    host.read_reg(iem_pkg::ADDR_STATUS, rd);
    `CHECK_EQ(rd, 16'h4000)
    host.write_reg(10'h3FF, 16'hFFFF);
    host.read_reg(10'h3FF, rd);
    `CHECK_EQ(rd, 16'h0000)
    host.read_reg(iem_pkg::ADDR_MASK, rd);
    `CHECK_EQ(rd, 16'h4000)
    host.write_reg(iem_pkg::ADDR_STATUS, 16'h0000);
    wait_edges(1);
    `CHECK_EQ(irq_out, 1'b1)
    host.write_reg(iem_pkg::ADDR_STATUS, 16'h4000);
    wait_edges(1);
    `CHECK_EQ(irq_out, 1'b0)
    $display("test reset_values done");

    // Every level event but warning C: latched while masked, then enabled, then cleared
    for (int i = 0; i < 14; i++) begin
      if (i != 3 && i != 7) begin
        host.write_reg(iem_pkg::ADDR_MASK, 16'h0000);
        @(posedge clock_in);
        lv[i] <= 1'b1;
        wait_edges(2);
        `CHECK_EQ(irq_out, 1'b0)
        host.read_reg(iem_pkg::ADDR_STATUS, rd);
        `CHECK_EQ(rd, 16'h0001 << i)
        host.write_reg(iem_pkg::ADDR_MASK, 16'h0001 << i);
        wait_edges(1);
        `CHECK_EQ(irq_out, 1'b1)
        host.write_reg(iem_pkg::ADDR_STATUS, 16'h0000);
        wait_edges(1);
        `CHECK_EQ(irq_out, 1'b1)
        host.write_reg(iem_pkg::ADDR_STATUS, 16'h0001 << i);
        wait_edges(1);
        `CHECK_EQ(irq_out, 1'b0)
        @(posedge clock_in);
        lv[i] <= 1'b0;
      end
    end
    $display("test event_flags done");

    // Sample mode: the output is the ready pulse, one cycle late
    host.set_sample_mode();
    wait_edges(3);
    `CHECK_EQ(irq_out, 1'b0)
    @(posedge clock_in);
    sample_ready_in <= 1'b1;
    @(posedge clock_in);
    sample_ready_in <= 1'b0;
    #1;
    `CHECK_EQ(irq_out, 1'b1)
    wait_edges(1);
    `CHECK_EQ(irq_out, 1'b0)
    $display("test sample_mode done");

    // Warning C filter: reserved bit, bypass, thresholds, glitch, length, enable
    host.write_reg(iem_pkg::ADDR_FILT_C, 16'hFFFF);
    host.read_reg(iem_pkg::ADDR_FILT_C, rd);
    `CHECK_EQ(rd, 16'hDFFF)
    host.write_reg(iem_pkg::ADDR_FILT_C, 16'h8000);
    @(posedge clock_in);
    adc <= 8'h41;
    wait_edges(3);
    `CHECK_EQ({ch2_warn_c_out, ch1_warn_c_out}, 2'b11)
    host.read_reg(iem_pkg::ADDR_STATUS, rd);
    `CHECK_EQ(rd, 16'h0088)
    @(posedge clock_in);
    adc <= 8'h30;
    wait_edges(3);
    `CHECK_EQ(ch1_warn_c_out, 1'b1)
    @(posedge clock_in);
    adc <= 8'h20;
    wait_edges(3);
    `CHECK_EQ(ch1_warn_c_out, 1'b0)
    host.write_reg(iem_pkg::ADDR_FILT_C, 16'h8002);
    @(posedge clock_in);
    adc <= 8'h50;
    repeat (150) @(posedge clock_in);
    adc <= 8'h10;
    wait_edges(600);
    `CHECK_EQ(ch1_warn_c_out, 1'b0)
    @(posedge clock_in);
    adc <= 8'h50;
    wait_edges(1000);
    `CHECK_EQ({ch2_warn_c_out, ch1_warn_c_out}, 2'b11)
    host.write_reg(iem_pkg::ADDR_FILT_C, 16'h0000);
    wait_edges(4);
    `CHECK_EQ(ch1_warn_c_out, 1'b0)
    // Up/down, length 8: a short revert only backs the count off,
    // so 3 to 5 more ticks finish where up/clear would need all 8
    @(posedge clock_in);
    adc <= 8'h10;
    host.write_reg(iem_pkg::ADDR_FILT_C, 16'hC008);
    @(posedge clock_in);
    adc <= 8'h50;
    repeat (1100) @(posedge clock_in);
    adc <= 8'h10;
    wait_edges(300);
    `CHECK_EQ(ch1_warn_c_out, 1'b0)
    @(posedge clock_in);
    adc <= 8'h50;
    wait_edges(1200);
    `CHECK_EQ({ch2_warn_c_out, ch1_warn_c_out}, 2'b11)
    host.restore_cfg(16'h80FA);
    host.read_reg(iem_pkg::ADDR_FILT_C, rd);
    `CHECK_EQ(rd, 16'h80FA)
    $display("test warning_filter done");
    give_verdict();
  end
endmodule : tb_top
